//--- hw/wpr_pkg.sv
// package: constants and types for the word pattern recognizer
package wpr_pkg;
   localparam int SETUP_BITS = 40;
   localparam int CTRL_BITS = 36;
   localparam int STAGE_BITS = 8;
   localparam int NUM_DATA = 16;
   // bit positions inside the setup register (bit 0 = last bit shifted in)
   localparam int POS_MATCH_HI = 0;
   localparam int POS_EN_HI = 8;
   localparam int POS_EN_LO = 16;
   localparam int POS_MATCH_LO = 24;
   localparam int POS_QUAL_EN = 32;
   localparam int POS_QUAL_MATCH = 33;
   localparam int POS_EDGE_SEL = 34;
   localparam int POS_SYNC_SEL = 35;
   localparam int POS_ECHO = 39;
   localparam logic [39:0] SETUP_RESET = 40'h00_0000_0000;
   // high-going delay on the asynchronous path
   localparam int ASYNC_RISE_MIN_NS = 35;
   localparam int ASYNC_RISE_MAX_NS = 60;
   localparam int MCLK_PERIOD_NS = 8;
   localparam int ASYNC_RISE_CYC = (ASYNC_RISE_MIN_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
   localparam logic [3:0] ASYNC_RISE_CNT = 4'(ASYNC_RISE_CYC);

   typedef struct packed {
      logic sync_sel;
      logic edge_sel;
      logic qual_match;
      logic qual_en;
      logic [15:0] match_bits;
      logic [15:0] enable_bits;
   } wpr_ctrl_type;
endpackage

//--- hw/wpr_word_recognizer.sv
// word pattern recognizer: serial setup register, gating, compare, sync and output
// Contract
// - a 40-bit serial shift register loads on the setup shift clock, last 36 bits shifted in are control.
// - the last register bit is echoed out and reads low after one to three surplus shifts.
// - an enabled data input reaches the compare inverted, a disabled one is forced high.
// - the qualifier passes when its enable bit is low and is forced high when it is high.
// - the upper-byte compare is always enabled and goes low when all eight inputs match.
// - the lower-byte compare is enabled only when the gated qualifier equals its match bit.
// - both compare results combine into one active-low match signal.
// - control bit 35 selects the synchronized match when high, combinational when low.
// - on the asynchronous path high-going output edges are delayed 35 to 60 ns.
// - the edge select bit low uses the sample clock as is, high uses it inverted.
// - at each active sample edge the synchronizer goes low when the match is low.
// - while low, the opposite sample edge sets the synchronizer back high.
// - all five eight-bit stages shift on the same setup clock edge.
`timescale 1ns/1ps
module wpr_word_recognizer
   import wpr_pkg::*;
#(
   parameter int SYNC_STAGES = 2
)
(
   // system
   input wire logic mclk,
   input wire logic rst,
   // setup load port
   input wire logic setup_data,
   input wire logic setup_shift_clock,
   output logic setup_echo_bit,
   // probe
   input wire logic [15:0] probe_data_inputs,
   input wire logic probe_qualifier,
   input wire logic probe_clock,
   // result
   output logic word_match_n
);
   initial
   begin
      if (SYNC_STAGES != 2)
         $error("wpr_word_recognizer: SYNC_STAGES must be 2");
   end

   // two-flop synchronisers for every outside input; stage 1 read only by stage 2
   localparam int NSYN = 20;
   logic [NSYN-1:0] raw_in;
   logic [NSYN-1:0] syn1_reg;
   logic [NSYN-1:0] syn2_reg;
   assign raw_in = {probe_clock, setup_shift_clock, setup_data, probe_qualifier, probe_data_inputs};
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         syn1_reg <= '0;
         syn2_reg <= '0;
      end
      else
      begin
         syn1_reg <= raw_in;
         syn2_reg <= syn1_reg;
      end
   end
   logic [15:0] data_s;
   logic qual_s;
   logic sdata_s;
   logic sclk_s;
   logic pclk_s;
   assign data_s = syn2_reg[15:0];
   assign qual_s = syn2_reg[16];
   assign sdata_s = syn2_reg[17];
   assign sclk_s = syn2_reg[18];
   assign pclk_s = syn2_reg[19];

   // edge history and setup register
   logic sclk_d_reg;
   logic pclk_d_reg;
   logic [39:0] setup_reg;
   logic [39:0] setup_next;
   logic sclk_rise;
   assign sclk_rise = sclk_s & ~sclk_d_reg;
   always_comb
   begin
      setup_next = setup_reg;
      if (sclk_rise)
         setup_next = {setup_reg[38:0], sdata_s};
   end
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         setup_reg <= SETUP_RESET;
         sclk_d_reg <= 1'b0;
         pclk_d_reg <= 1'b0;
      end
      else
      begin
         setup_reg <= setup_next;
         sclk_d_reg <= sclk_s;
         pclk_d_reg <= pclk_s;
      end
   end
   assign setup_echo_bit = setup_reg[POS_ECHO];

   wpr_ctrl_type ctrl;
   assign ctrl.match_bits = {setup_reg[POS_MATCH_HI +: 8], setup_reg[POS_MATCH_LO +: 8]};
   assign ctrl.enable_bits = {setup_reg[POS_EN_HI +: 8], setup_reg[POS_EN_LO +: 8]};
   assign ctrl.qual_en = setup_reg[POS_QUAL_EN];
   assign ctrl.qual_match = setup_reg[POS_QUAL_MATCH];
   assign ctrl.edge_sel = setup_reg[POS_EDGE_SEL];
   assign ctrl.sync_sel = setup_reg[POS_SYNC_SEL];

   // gating and compare
   logic [15:0] gated;
   logic [15:0] eq;
   genvar gi;
   generate
      for (gi = 0; gi < NUM_DATA; gi++)
      begin : g_bit
         assign gated[gi] = ~(ctrl.enable_bits[gi] & data_s[gi]);
         assign eq[gi] = (gated[gi] == ctrl.match_bits[gi]);
      end
   endgenerate
   logic qual_gated;
   assign qual_gated = qual_s | ctrl.qual_en;
   logic hi_cmp_n;
   logic lo_cmp_n;
   logic match_n;
   assign hi_cmp_n = ~(&eq[15:8]);
   assign lo_cmp_n = ~((qual_gated == ctrl.qual_match) & (&eq[7:0]));
   assign match_n = hi_cmp_n | lo_cmp_n;

   logic sclk_sel;
   logic sclk_sel_d;
   assign sclk_sel = pclk_s ^ ctrl.edge_sel;
   assign sclk_sel_d = pclk_d_reg ^ ctrl.edge_sel;
   logic act_edge;
   logic opp_edge;
   assign act_edge = sclk_sel & ~sclk_sel_d;
   assign opp_edge = ~sclk_sel & sclk_sel_d;

   logic sync_n_reg;
   logic sync_n_next;
   logic [3:0] rise_cnt_reg;
   logic [3:0] rise_cnt_next;
   logic async_n_reg;
   logic async_n_next;
   logic word_n_reg;
   logic word_n_next;
   always_comb
   begin
      sync_n_next = sync_n_reg;
      if (act_edge && !match_n)
         sync_n_next = 1'b0;
      else if (opp_edge && !sync_n_reg)
         sync_n_next = 1'b1;
      async_n_next = async_n_reg;
      rise_cnt_next = '0;
      if (!match_n)
         async_n_next = 1'b0;
      else if (!async_n_reg)
      begin
         rise_cnt_next = rise_cnt_reg + 4'h1;
         if (rise_cnt_reg == ASYNC_RISE_CNT - 4'h1)
         begin
            async_n_next = 1'b1;
            rise_cnt_next = '0;
         end
      end
      word_n_next = ctrl.sync_sel ? sync_n_reg : async_n_next;
   end
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         sync_n_reg <= 1'b1;
         async_n_reg <= 1'b1;
         rise_cnt_reg <= '0;
         word_n_reg <= 1'b1;
      end
      else
      begin
         sync_n_reg <= sync_n_next;
         async_n_reg <= async_n_next;
         rise_cnt_reg <= rise_cnt_next;
         word_n_reg <= word_n_next;
      end
   end
   assign word_match_n = word_n_reg;

   // checks
   // capture
   a_sync_capture: assert property (@(posedge mclk) disable iff (rst)
      (act_edge && !match_n) |=> !sync_n_reg) else $error("sync did not capture match");
   a_sync_release: assert property (@(posedge mclk) disable iff (rst)
      (opp_edge && !sync_n_reg && !act_edge) |=> sync_n_reg) else $error("sync not released");
   a_async_rise: assert property (@(posedge mclk) disable iff (rst)
      ($rose(async_n_reg)) |-> $past(match_n, 1) && $past(match_n, 4))
      else $error("async rose too early");
   a_async_fall: assert property (@(posedge mclk) disable iff (rst)
      !match_n |=> !async_n_reg) else $error("async fall slow");
   a_out_async: assert property (@(posedge mclk) disable iff (rst)
      !ctrl.sync_sel && !match_n |=> !word_match_n) else $error("async match missing");
   a_out_sync: assert property (@(posedge mclk) disable iff (rst)
      $past(ctrl.sync_sel) && ctrl.sync_sel |-> word_match_n == $past(sync_n_reg))
      else $error("sync output mismatch");
   a_setup_shift: assert property (@(posedge mclk) disable iff (rst)
      sclk_rise |=> setup_reg[0] == $past(sdata_s)) else $error("setup shift lost");
   a_echo_bit: assert property (@(posedge mclk) disable iff (rst)
      sclk_rise |=> setup_echo_bit == $past(setup_reg[38])) else $error("echo wrong");
   a_qual_block: assert property (@(posedge mclk) disable iff (rst)
      (qual_gated != ctrl.qual_match) |-> match_n) else $error("qualifier ignored");
   c_sync_hit: cover property (@(posedge mclk) disable iff (rst) $fell(sync_n_reg));
   c_async_hit: cover property (@(posedge mclk) disable iff (rst) $rose(async_n_reg));
   c_load_ok: cover property (@(posedge mclk) disable iff (rst) $rose(setup_echo_bit));
endmodule // wpr_word_recognizer

//--- tb/wpr_probe_model.sv
// probe model: data word, qualifier and framed sample clock
`timescale 1ns/1ps
module wpr_probe_model
(
   // system
   input wire logic mclk,
   // probe lines
   output logic [15:0] probe_data_inputs,
   output logic probe_qualifier,
   output logic probe_clock
);
   initial
   begin
      probe_data_inputs = 16'h0000;
      probe_qualifier = 1'b0;
      probe_clock = 1'b0;
   end

   task automatic set_word(input logic [15:0] d, input logic q);
      @(posedge mclk);
      probe_data_inputs <= d;
      probe_qualifier <= q;
   endtask

   // clock stands low between frames; the 3 ns offset keeps it off the mclk grid
   task automatic burst(input int n);
      #3;
      repeat (n)
      begin
         probe_clock = 1'b1;
         #32;
         probe_clock = 1'b0;
         #32;
      end
   endtask
endmodule // wpr_probe_model

//--- tb/word_pattern_recognizer_tb.sv
// testbench for the word pattern recognizer
`timescale 1ns/1ps
module word_pattern_recognizer_tb;
   import wpr_pkg::*;
   logic mclk, rst, setup_data, setup_shift_clock, setup_echo_bit, word_match_n, pq, pc, qv, qc;
   logic [15:0] pd, pat, care;
   int miscompares = 0;
   int comparisons = 0;

   wpr_probe_model probe (.mclk(mclk), .probe_data_inputs(pd), .probe_qualifier(pq),
      .probe_clock(pc));
   wpr_word_recognizer dut (.mclk(mclk), .rst(rst), .setup_data(setup_data),
      .setup_shift_clock(setup_shift_clock), .setup_echo_bit(setup_echo_bit),
      .probe_data_inputs(pd), .probe_qualifier(pq), .probe_clock(pc),
      .word_match_n(word_match_n));

   initial
   begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   task automatic check(input logic seen, input logic exp);
      comparisons++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("[FAIL] %0t ns: seen %b expected %b", $time, seen, exp);
      end
   endtask

   task automatic stop_test();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask

   // each shift clock level is held well past the two-cycle sampling need
   task automatic shift_bit(input logic b);
      setup_data <= b;
      wait_cyc(3);
      setup_shift_clock <= 1'b1;
      wait_cyc(4);
      setup_shift_clock <= 1'b0;
      wait_cyc(4);
   endtask

   task automatic load(input logic edge_s, input logic sync_s);
      logic [39:0] v;
      v = '0;
      v[POS_ECHO] = 1'b1;
      v[POS_MATCH_HI +: 8] = ~(pat[15:8] & care[15:8]);
      v[POS_EN_HI +: 8] = care[15:8];
      v[POS_EN_LO +: 8] = care[7:0];
      v[POS_MATCH_LO +: 8] = ~(pat[7:0] & care[7:0]);
      v[POS_QUAL_EN] = ~qc;
      v[POS_QUAL_MATCH] = qv | ~qc;
      v[POS_EDGE_SEL] = edge_s;
      v[POS_SYNC_SEL] = sync_s;
      for (int i = 39; i >= 0; i--)
         shift_bit(v[i]);
      wait_cyc(2);
      check(setup_echo_bit, 1'b1);
   endtask

   function automatic logic exp_n(input logic [15:0] d, input logic q);
      return !(((d ^ pat) & care) == 16'h0000 && (!qc || q == qv));
   endfunction

   initial
   begin
      logic [15:0] d;
      logic q;
      rst = 1'b1;
      setup_data = 1'b0;
      setup_shift_clock = 1'b0;
      void'($urandom(32'hd55e));
      wait_cyc(2);
      rst <= 1'b0;
      wait_cyc(1);
      check(setup_echo_bit, 1'b0);
      check(word_match_n, 1'b1);
      $display("test reset done");
      for (int t = 0; t < 3; t++)
      begin
         pat = $urandom;
         care = (t == 0) ? 16'hffff : (t == 1) ? 16'h0000 : 16'($urandom);
         qv = $urandom;
         qc = (t == 0) ? 1'b1 : 1'($urandom);
         load(1'b0, 1'b0);
         for (int k = 0; k < 16; k++)
         begin
            d = pat ^ (($urandom_range(1) == 0) ? 16'h0000 : 16'($urandom));
            q = (k[1:0] == 2'b11) ? ~qv : qv;
            probe.set_word(d, q);
            wait_cyc(12);
            check(word_match_n, exp_n(d, q));
         end
      end
      $display("test async compare done");
      care = 16'hffff;
      qc = 1'b1;
      load(1'b0, 1'b0);
      probe.set_word(pat, qv);
      wait_cyc(12);
      check(word_match_n, 1'b0);
      // compare goes high two cycles in: 32 ns later still low, 56 ns later high
      probe.set_word(~pat, qv);
      wait_cyc(6);
      check(word_match_n, 1'b0);
      wait_cyc(3);
      check(word_match_n, 1'b1);
      $display("test rise delay done");
      probe.set_word(pat, qv);
      for (int e = 0; e < 2; e++)
      begin
         load(e[0], 1'b1);
         wait_cyc(12);
         check(word_match_n, 1'b1);
         fork
            probe.burst(1);
            begin
               wait_cyc(7);
               check(word_match_n, e[0]);
            end
         join
         wait_cyc(6);
         check(word_match_n, ~e[0]);
         // mismatching word: with e = 1 the opposite edge releases, the active edge must not capture
         probe.set_word(~pat, qv);
         probe.burst(1);
         wait_cyc(6);
         check(word_match_n, 1'b1);
         probe.set_word(pat, qv);
      end
      $display("test sync edges done");
      for (int k = 0; k < 3; k++)
      begin
         shift_bit(1'b1);
         wait_cyc(2);
         check(setup_echo_bit, 1'b0);
      end
      $display("test surplus shifts done");
      stop_test();
   end
endmodule // word_pattern_recognizer_tb
